/* File: hw/program_flow_stack_table_read.sv */
// program counter, return stack, table read and alu sequencing of the core
`timescale 1ns/1ps
// Summary of operation
// - writing the pc low byte jumps in page and adds one dummy cycle
// - return stack holds four pc entries, hidden from software entirely
// - call or interrupt acknowledge pushes the pc onto the stack
// - both return kinds pop the stack into the pc
// - after reset the stack pointer indexes slot zero, the first slot pushed
// - interrupt with full stack is held unacknowledged until a return pops
// - call with full stack proceeds and drops the oldest entry
// - alu writes its result to the destination and updates status
// - alu does add, subtract, decimal adjust, logic, rotate, step, skip
// - program memory is 2K words of 15 bits, addressed by pc
// - reset loads the pc with address zero
// - table pointer low and high form the full table address
// - table read sends low byte to named register, rest to table high
// - standard table read takes its address from the full pointer pair
// - table data high is read only, written by table reads only
// - every table instruction takes two instruction cycles
// - pc is eleven bits: three hidden upper bits and a low byte
// - alu datapath is eight bits wide
module program_flow_stack_table_read
(
   // clock, reset, freeze
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic enable_i,
   // decoder command
   input flow_pkg::cmd_t cmd_i,
   output logic ready_o,
   // interrupt request and acknowledge
   input wire logic irq_pending_i,
   input wire logic [10:0] irq_vector_i,
   output logic irq_ack_o,
   // table pointers
   input wire logic [7:0] table_pointer_low_i,
   input wire logic [2:0] table_pointer_high_i,
   // program memory load port
   input flow_pkg::pm_wr_t pm_wr_i,
   // fetch
   output logic [10:0] pc_o,
   output logic [7:0] pc_low_byte_o,
   output logic [14:0] instr_o,
   output logic instr_valid_o,
   output logic stack_full_o,
   // table read result
   output logic [7:0] table_low_o,
   output logic [7:0] table_dest_o,
   output logic table_wr_o,
   output logic [6:0] table_data_high_o,
   // alu result
   output logic [7:0] alu_result_o,
   output flow_pkg::status_t status_o,
   output logic [7:0] alu_dest_o,
   output logic alu_wr_o
);

   // ==================================================
   // state and helpers
   flow_pkg::flow_regs_t q_q;
   flow_pkg::flow_regs_t q_d;
   flow_pkg::alu_out_t alu_now;
   logic [10:0] rd_addr;
   logic [14:0] rd_data;
   logic [10:0] stack_top;
   logic [10:0] pc_plus1;
   logic [10:0] low_target;
   logic [10:0] tbl_addr;
   logic full;
   logic irq_take;
   logic cmd_take;
   logic tbl_fetch;

   // push onto the circular stack; when full the oldest slot is overwritten
   function automatic flow_pkg::flow_regs_t push(input flow_pkg::flow_regs_t s, input logic [10:0] v);
      flow_pkg::flow_regs_t r;
      r = s;
      // write pulses of the last cycle must not repeat
      r.tbl_wr = 1'b0;
      r.alu_wr = 1'b0;
      r.stk[s.wp] = v;
      r.wp = s.wp + flow_pkg::PTR_STEP;
      if (s.cnt != flow_pkg::STACK_LEVELS)
      begin
         r.cnt = s.cnt + flow_pkg::CNT_STEP;
      end
      return r;
   endfunction

   // ==================================================
   // alu, fed straight from the decoder operands
   flow_alu u_alu
   (
      .op_i(cmd_i.alu_op),
      .a_i(cmd_i.a),
      .b_i(cmd_i.b),
      .status_i(q_q.status),
      .out_o(alu_now)
   );

   // program memory, shared by fetch and table reads
   prog_mem u_mem
   (
      .clock_i(clock_i),
      .rst_b_i(rst_b_i),
      .en_i(enable_i),
      .wr_i(pm_wr_i),
      .rd_addr_i(rd_addr),
      .rd_data_o(rd_data)
   );

   // ==================================================
   // combinational helpers
   assign stack_top = q_q.stk[q_q.wp - flow_pkg::PTR_STEP];
   assign pc_plus1 = q_q.pc + flow_pkg::PC_STEP;
   assign low_target = {q_q.pc[10:8], cmd_i.operand};
   assign tbl_addr = {table_pointer_high_i, table_pointer_low_i};
   assign full = (q_q.cnt == flow_pkg::STACK_LEVELS);
   // a full stack holds the interrupt back, it stays pending outside
   assign irq_take = enable_i && q_q.state == flow_pkg::ST_EXEC && irq_pending_i && !full;
   assign cmd_take = enable_i && q_q.state == flow_pkg::ST_EXEC && cmd_i.valid && !irq_take;

   // ==================================================
   // next state
   always_comb
   begin
      q_d = q_q;
      q_d.tbl_wr = 1'b0;
      q_d.alu_wr = 1'b0;
      tbl_fetch = 1'b0;
      rd_addr = q_q.pc;
      case (q_q.state)
         flow_pkg::ST_EXEC:
         begin
            if (irq_take)
            begin
               // interrupt takes the slot; the pending instruction reruns later
               q_d = push(q_q, q_q.pc);
               q_d.pc = irq_vector_i;
               q_d.state = flow_pkg::ST_DUMMY;
            end
            else if (cmd_take)
            begin
               q_d.pc = pc_plus1;
               case (cmd_i.op)
                  flow_pkg::OP_ALU:
                  begin
                     q_d.alu_res = alu_now.result;
                     q_d.status = alu_now.status;
                     q_d.alu_dest = cmd_i.dest;
                     q_d.alu_wr = 1'b1;
                     if (alu_now.skip)
                     begin
                        // the prefetched next word is dropped
                        q_d.pc = q_q.pc + flow_pkg::PC_SKIP_STEP;
                        q_d.state = flow_pkg::ST_DUMMY;
                     end
                  end
                  flow_pkg::OP_JMP:
                  begin
                     q_d.pc = cmd_i.target;
                     q_d.state = flow_pkg::ST_DUMMY;
                  end
                  flow_pkg::OP_CALL:
                  begin
                     q_d = push(q_q, pc_plus1);
                     q_d.pc = cmd_i.target;
                     q_d.state = flow_pkg::ST_DUMMY;
                  end
                  flow_pkg::OP_SUB_RETURN, flow_pkg::OP_INT_RETURN:
                  begin
                     // popping an empty stack wraps the pointer and stays empty
                     q_d.pc = stack_top;
                     q_d.wp = q_q.wp - flow_pkg::PTR_STEP;
                     if (q_q.cnt != 3'h0)
                     begin
                        q_d.cnt = q_q.cnt - flow_pkg::CNT_STEP;
                     end
                     q_d.state = flow_pkg::ST_DUMMY;
                  end
                  flow_pkg::OP_LOW_WR:
                  begin
                     q_d.pc = low_target;
                     q_d.state = flow_pkg::ST_DUMMY;
                  end
                  flow_pkg::OP_TBL_STD:
                  begin
                     tbl_fetch = 1'b1;
                     rd_addr = tbl_addr;
                     q_d.tbl_dest = cmd_i.dest;
                     q_d.state = flow_pkg::ST_TABLE;
                  end
                  flow_pkg::OP_TBL_LAST:
                  begin
                     tbl_fetch = 1'b1;
                     rd_addr = {flow_pkg::LAST_PAGE, table_pointer_low_i};
                     q_d.tbl_dest = cmd_i.dest;
                     q_d.state = flow_pkg::ST_TABLE;
                  end
                  default: ;
               endcase
            end
         end
         flow_pkg::ST_DUMMY:
         begin
            // target word is fetched now, nothing executes
            q_d.state = flow_pkg::ST_EXEC;
         end
         flow_pkg::ST_TABLE:
         begin
            // second cycle: the table word is on the read port
            q_d.tbl_low = rd_data[flow_pkg::LOW_BYTE_MSB:0];
            q_d.tbl_high = rd_data[flow_pkg::WORD_W-1:flow_pkg::HIGH_BITS_LSB];
            q_d.tbl_wr = 1'b1;
            q_d.state = flow_pkg::ST_EXEC;
         end
         default: q_d.state = flow_pkg::ST_EXEC;
      endcase
      if (!tbl_fetch)
      begin
         rd_addr = q_d.pc;
      end
      q_d.fetch_ok = (q_d.state == flow_pkg::ST_EXEC);
      // freeze everything while the enable is low
      if (!enable_i)
      begin
         q_d = q_q;
      end
   end

   // ==================================================
   // state register
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         q_q <= '0;
         q_q.pc <= flow_pkg::RESET_VECTOR;
         q_q.state <= flow_pkg::ST_EXEC;
      end
      else
      begin
         q_q <= q_d;
      end
   end

   // ==================================================
   // outputs
   assign ready_o = cmd_take || (enable_i && q_q.state == flow_pkg::ST_EXEC && !irq_take);
   assign irq_ack_o = irq_take;
   assign pc_o = q_q.pc;
   assign pc_low_byte_o = q_q.pc[7:0];
   assign instr_o = rd_data;
   assign instr_valid_o = q_q.fetch_ok;
   assign stack_full_o = full;
   assign table_low_o = q_q.tbl_low;
   assign table_dest_o = q_q.tbl_dest;
   assign table_wr_o = q_q.tbl_wr;
   assign table_data_high_o = q_q.tbl_high;
   assign alu_result_o = q_q.alu_res;
   assign status_o = q_q.status;
   assign alu_dest_o = q_q.alu_dest;
   assign alu_wr_o = q_q.alu_wr;

   // ==================================================
   // assertions
   default clocking cb @(posedge clock_i);
   endclocking
   default disable iff (!rst_b_i || !enable_i);

   property p_low_wr_dummy;
      cmd_take && cmd_i.op == flow_pkg::OP_LOW_WR
      |=> !instr_valid_o && pc_o == $past(low_target) ##1 instr_valid_o;
   endproperty
   a_low_wr_dummy: assert property (p_low_wr_dummy) else $error("pc low write missed dummy");

   property p_depth;
      q_q.cnt <= flow_pkg::STACK_LEVELS;
   endproperty
   a_depth: assert property (p_depth) else $error("stack depth above four");

   property p_call_push;
      cmd_take && cmd_i.op == flow_pkg::OP_CALL |=> stack_top == $past(pc_plus1);
   endproperty
   a_call_push: assert property (p_call_push) else $error("call did not push return");

   property p_return_pop;
      cmd_take && (cmd_i.op == flow_pkg::OP_SUB_RETURN || cmd_i.op == flow_pkg::OP_INT_RETURN) && q_q.cnt != 3'h0
      |=> pc_o == $past(stack_top) && q_q.cnt == $past(q_q.cnt) - 3'h1;
   endproperty
   a_return_pop: assert property (p_return_pop) else $error("return did not pop");

   property p_reset_state;
      !$past(rst_b_i) |-> q_q.cnt == 3'h0 && pc_o == flow_pkg::RESET_VECTOR;
   endproperty
   a_reset_state: assert property (p_reset_state) else $error("bad state after reset");

   property p_irq_hold;
      irq_pending_i && full |-> !irq_ack_o;
   endproperty
   a_irq_hold: assert property (p_irq_hold) else $error("interrupt taken on full stack");

   property p_overflow;
      cmd_take && cmd_i.op == flow_pkg::OP_CALL && full
      |=> q_q.cnt == flow_pkg::STACK_LEVELS && pc_o == $past(cmd_i.target);
   endproperty
   a_overflow: assert property (p_overflow) else $error("full call misbehaved");

   property p_alu_write;
      cmd_take && cmd_i.op == flow_pkg::OP_ALU
      |=> alu_wr_o && alu_result_o == $past(alu_now.result) && status_o == $past(alu_now.status);
   endproperty
   a_alu_write: assert property (p_alu_write) else $error("alu result not written");

   property p_table_two;
      cmd_take && (cmd_i.op == flow_pkg::OP_TBL_STD || cmd_i.op == flow_pkg::OP_TBL_LAST)
      |=> !ready_o && !table_wr_o ##1 table_wr_o && table_data_high_o == $past(instr_o[14:8]);
   endproperty
   a_table_two: assert property (p_table_two) else $error("table read not two cycles");

   property p_table_addr;
      cmd_take && cmd_i.op == flow_pkg::OP_TBL_STD |-> rd_addr == tbl_addr;
   endproperty
   a_table_addr: assert property (p_table_addr) else $error("table address wrong");

   property p_last_page;
      cmd_take && cmd_i.op == flow_pkg::OP_TBL_LAST |-> rd_addr == {flow_pkg::LAST_PAGE, table_pointer_low_i};
   endproperty
   a_last_page: assert property (p_last_page) else $error("last page address wrong");

   property p_cov_overflow;
      cmd_take && cmd_i.op == flow_pkg::OP_CALL && full;
   endproperty
   c_cov_overflow: cover property (p_cov_overflow);

   property p_cov_irq_wait;
      irq_pending_i && full ##[1:50] irq_ack_o;
   endproperty
   c_cov_irq_wait: cover property (p_cov_irq_wait);

   property p_cov_table;
      cmd_take && cmd_i.op == flow_pkg::OP_TBL_LAST ##2 table_wr_o;
   endproperty
   c_cov_table: cover property (p_cov_table);

endmodule // program_flow_stack_table_read

/* File: hw/flow_pkg.sv */
// shared constants, types and the state record of the program flow block
package flow_pkg;

   // ==================================================
   // sizes
   localparam int PC_W = 11;
   localparam int WORD_W = 15;
   localparam int DATA_W = 8;
   localparam int HI_W = 7;
   localparam int PM_WORDS = 2048;
   localparam int STACK_DEPTH = 4;

   // ==================================================
   // fixed addresses and counts
   localparam logic [10:0] RESET_VECTOR = 11'h000;
   localparam logic [2:0] LAST_PAGE = 3'h7;
   localparam logic [2:0] STACK_LEVELS = 3'h4;
   localparam logic [1:0] PTR_STEP = 2'h1;
   localparam logic [2:0] CNT_STEP = 3'h1;
   localparam logic [10:0] PC_STEP = 11'h001;
   localparam logic [10:0] PC_SKIP_STEP = 11'h002;
   localparam int LOW_BYTE_MSB = 7;
   localparam int HIGH_BITS_LSB = 8;

   // ==================================================
   // operation codes from the decoder
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_ALU = 4'h1,
      OP_JMP = 4'h2,
      OP_CALL = 4'h3,
      OP_SUB_RETURN = 4'h4,
      OP_INT_RETURN = 4'h5,
      OP_LOW_WR = 4'h6,
      OP_TBL_STD = 4'h7,
      OP_TBL_LAST = 4'h8
   } flow_op_t;

   typedef enum logic [4:0] {
      ALU_ADD = 5'h00,
      ALU_ADC = 5'h01,
      ALU_SUB = 5'h02,
      ALU_SBC = 5'h03,
      ALU_DAA = 5'h04,
      ALU_AND = 5'h05,
      ALU_OR = 5'h06,
      ALU_XOR = 5'h07,
      ALU_CPL = 5'h08,
      ALU_RR = 5'h09,
      ALU_RRC = 5'h0a,
      ALU_RL = 5'h0b,
      ALU_RLC = 5'h0c,
      ALU_INC = 5'h0d,
      ALU_DEC = 5'h0e,
      ALU_SKIP_Z = 5'h0f,
      ALU_SKIP_NZ = 5'h10,
      ALU_INC_SKIP_Z = 5'h11,
      ALU_DEC_SKIP_Z = 5'h12,
      ALU_PASS = 5'h13
   } alu_op_t;

   // ==================================================
   // carriers
   typedef struct packed {
      logic ov;
      logic z;
      logic ac;
      logic c;
   } status_t;

   typedef struct packed {
      logic valid;
      flow_op_t op;
      alu_op_t alu_op;
      logic [10:0] target;
      logic [7:0] operand;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] dest;
   } cmd_t;

   typedef struct packed {
      logic [7:0] result;
      status_t status;
      logic skip;
   } alu_out_t;

   typedef struct packed {
      logic en;
      logic [10:0] addr;
      logic [14:0] data;
   } pm_wr_t;

   typedef enum logic [1:0] {
      ST_EXEC = 2'b00,
      ST_DUMMY = 2'b01,
      ST_TABLE = 2'b10
   } flow_state_t;

   typedef struct packed {
      flow_state_t state;
      logic [10:0] pc;
      logic [3:0][10:0] stk;
      logic [1:0] wp;
      logic [2:0] cnt;
      logic fetch_ok;
      logic [7:0] tbl_low;
      logic [6:0] tbl_high;
      logic [7:0] tbl_dest;
      logic tbl_wr;
      logic [7:0] alu_res;
      status_t status;
      logic [7:0] alu_dest;
      logic alu_wr;
   } flow_regs_t;

endpackage

/* File: hw/prog_mem.sv */
// program memory array with a registered read port and a load port
`timescale 1ns/1ps
module prog_mem
(
   // clock and freeze
   input wire logic clock_i,
   input wire logic rst_b_i,
   input wire logic en_i,
   // load port
   input flow_pkg::pm_wr_t wr_i,
   // read port
   input wire logic [10:0] rd_addr_i,
   output logic [14:0] rd_data_o
);

   // ==================================================
   // storage, no reset on the array itself
   logic [14:0] mem [flow_pkg::PM_WORDS];
   logic [14:0] rd_data_q;

   // load writes take one enabled edge
   always_ff @(posedge clock_i)
   begin
      if (en_i && wr_i.en)
      begin
         mem[wr_i.addr] <= wr_i.data;
      end
   end

   // registered read, one cycle latency
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         rd_data_q <= 15'h0000;
      end
      else if (en_i)
      begin
         rd_data_q <= mem[rd_addr_i];
      end
   end

   assign rd_data_o = rd_data_q;

endmodule // prog_mem

/* File: hw/flow_alu.sv */
// eight bit arithmetic and logic unit with status and skip decision
`timescale 1ns/1ps
module flow_alu
(
   // operation and operands
   input flow_pkg::alu_op_t op_i,
   input wire logic [7:0] a_i,
   input wire logic [7:0] b_i,
   input flow_pkg::status_t status_i,
   // result
   output flow_pkg::alu_out_t out_o
);

   logic [7:0] bb;
   logic cin;
   logic [8:0] sum;
   logic [4:0] nib;
   logic [7:0] adj;

   // ==================================================
   // one case per operation class
   always_comb
   begin
      out_o = '0;
      out_o.result = b_i;
      out_o.status = status_i;
      bb = b_i;
      cin = 1'b0;
      sum = 9'h000;
      nib = 5'h00;
      adj = 8'h00;
      case (op_i)
         flow_pkg::ALU_ADD, flow_pkg::ALU_ADC, flow_pkg::ALU_SUB, flow_pkg::ALU_SBC:
         begin
            // subtract as add of complement, carry means no borrow
            bb = (op_i == flow_pkg::ALU_SUB || op_i == flow_pkg::ALU_SBC) ? ~b_i : b_i;
            cin = (op_i == flow_pkg::ALU_SUB) ? 1'b1 : (op_i == flow_pkg::ALU_ADD) ? 1'b0 : status_i.c;
            sum = {1'b0, a_i} + {1'b0, bb} + {8'h00, cin};
            nib = {1'b0, a_i[3:0]} + {1'b0, bb[3:0]} + {4'h0, cin};
            out_o.result = sum[7:0];
            out_o.status.c = sum[8];
            out_o.status.ac = nib[4];
            out_o.status.ov = (a_i[7] == bb[7]) && (sum[7] != a_i[7]);
            out_o.status.z = (sum[7:0] == 8'h00);
         end
         flow_pkg::ALU_DAA:
         begin
            // decimal adjust only touches carry
            if (a_i[3:0] > 4'h9 || status_i.ac)
            begin
               adj[3:0] = 4'h6;
            end
            if (a_i[7:4] > 4'h9 || status_i.c || (a_i[7:4] == 4'h9 && a_i[3:0] > 4'h9))
            begin
               adj[7:4] = 4'h6;
            end
            sum = {1'b0, a_i} + {1'b0, adj};
            out_o.result = sum[7:0];
            out_o.status.c = status_i.c | sum[8];
         end
         flow_pkg::ALU_AND: out_o.result = a_i & b_i;
         flow_pkg::ALU_OR: out_o.result = a_i | b_i;
         flow_pkg::ALU_XOR: out_o.result = a_i ^ b_i;
         flow_pkg::ALU_CPL: out_o.result = ~a_i;
         flow_pkg::ALU_RR: out_o.result = {a_i[0], a_i[7:1]};
         flow_pkg::ALU_RRC: {out_o.result, out_o.status.c} = {status_i.c, a_i};
         flow_pkg::ALU_RL: out_o.result = {a_i[6:0], a_i[7]};
         flow_pkg::ALU_RLC: {out_o.status.c, out_o.result} = {a_i, status_i.c};
         flow_pkg::ALU_INC, flow_pkg::ALU_INC_SKIP_Z: out_o.result = a_i + 8'h01;
         flow_pkg::ALU_DEC, flow_pkg::ALU_DEC_SKIP_Z: out_o.result = a_i - 8'h01;
         flow_pkg::ALU_SKIP_Z, flow_pkg::ALU_SKIP_NZ: out_o.result = a_i;
         default: out_o.result = b_i;
      endcase
      // zero flag follows logic and step results; skip forms leave status alone
      case (op_i)
         flow_pkg::ALU_AND, flow_pkg::ALU_OR, flow_pkg::ALU_XOR, flow_pkg::ALU_CPL,
         flow_pkg::ALU_INC, flow_pkg::ALU_DEC:
            out_o.status.z = (out_o.result == 8'h00);
         default: ;
      endcase
      out_o.skip = (op_i == flow_pkg::ALU_SKIP_NZ) ? (a_i != 8'h00) :
                   (op_i == flow_pkg::ALU_SKIP_Z || op_i == flow_pkg::ALU_INC_SKIP_Z ||
                    op_i == flow_pkg::ALU_DEC_SKIP_Z) && (out_o.result == 8'h00);
   end

endmodule // flow_alu

/* File: tb/flow_decoder_model.sv */
// decoder model that offers one command at a time to the flow block
`timescale 1ns/1ps
module flow_decoder_model
(
   // clock and reset
   input wire logic clock_i,
   input wire logic rst_b_i,
   // bench request
   input flow_pkg::cmd_t next_i,
   input wire logic go_i,
   output logic busy_o,
   // core side
   input wire logic ready_i,
   input wire logic instr_valid_i,
   output flow_pkg::cmd_t cmd_o
);
   // ==================================================
   // offer and hold
   flow_pkg::cmd_t hold_q;
   logic pend_q;
   // idle fields show the inverse, so a stale command never looks live
   always_comb
   begin
      cmd_o = pend_q ? hold_q : flow_pkg::cmd_t'(~hold_q);
      cmd_o.valid = pend_q & instr_valid_i;
   end
   // a taken command wins over a new request, so one go is one command
   always_ff @(posedge clock_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         pend_q <= 1'b0;
         hold_q <= '0;
      end
      else if (cmd_o.valid && ready_i)
         pend_q <= 1'b0;
      else if (go_i && !pend_q)
      begin
         pend_q <= 1'b1;
         hold_q <= next_i;
      end
   end
   assign busy_o = pend_q;
endmodule // flow_decoder_model

/* File: tb/tb_program_flow_stack_table_read.sv */
// self-checking bench of the program flow block
`timescale 1ns/1ps
module tb_program_flow_stack_table_read;
   // ==================================================
   // signals
   localparam logic [10:0] VEC = 11'h004;
   logic clock_i = 1'b0;
   logic rst_b_i = 1'b0;
   logic go = 1'b0;
   logic en = 1'b1;
   logic irq_pending = 1'b0;
   logic [7:0] tp_low = 8'h00;
   logic [2:0] tp_high = 3'h0;
   flow_pkg::pm_wr_t pm_wr = '0;
   flow_pkg::cmd_t next_c = '0;
   flow_pkg::cmd_t cmd;
   flow_pkg::status_t st;
   logic busy, ready, ack, ivalid, full, twr, awr;
   logic [10:0] pc, epc;
   logic [10:0] ret [5];
   logic [7:0] pc_low_byte, tlow, tdest, ares, adest;
   logic [14:0] instr;
   logic [6:0] thigh;
   int n_mismatch = 0;
   int compares = 0;
   int n;
   typedef struct packed {
      flow_pkg::alu_op_t op;
      logic [7:0] a;
      logic [7:0] b;
      logic [7:0] res;
      logic c;
   } row_t;
   row_t rows [11] = '{
      '{flow_pkg::ALU_ADD, 8'h3c, 8'ha5, 8'he1, 1'b0},
      '{flow_pkg::ALU_ADD, 8'hff, 8'h01, 8'h00, 1'b1},
      '{flow_pkg::ALU_SUB, 8'h3c, 8'ha5, 8'h97, 1'b0},
      '{flow_pkg::ALU_AND, 8'h3c, 8'ha5, 8'h24, 1'b0},
      '{flow_pkg::ALU_OR, 8'h3c, 8'ha5, 8'hbd, 1'b0},
      '{flow_pkg::ALU_XOR, 8'h3c, 8'ha5, 8'h99, 1'b0},
      '{flow_pkg::ALU_CPL, 8'h5a, 8'h5a, 8'ha5, 1'b0},
      '{flow_pkg::ALU_RR, 8'h81, 8'h81, 8'hc0, 1'b0},
      '{flow_pkg::ALU_RL, 8'h81, 8'h81, 8'h03, 1'b0},
      '{flow_pkg::ALU_INC, 8'h7f, 8'h7f, 8'h80, 1'b0},
      '{flow_pkg::ALU_DEC, 8'h01, 8'h01, 8'h00, 1'b0}
   };
   // ==================================================
   // design and decoder
   // interrupt entry is tied to one vector
   program_flow_stack_table_read i_program_flow_stack_table_read
   (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .enable_i(en), .cmd_i(cmd), .ready_o(ready),
      .irq_pending_i(irq_pending), .irq_vector_i(VEC), .irq_ack_o(ack),
      .table_pointer_low_i(tp_low), .table_pointer_high_i(tp_high), .pm_wr_i(pm_wr),
      .pc_o(pc), .pc_low_byte_o(pc_low_byte), .instr_o(instr), .instr_valid_o(ivalid), .stack_full_o(full),
      .table_low_o(tlow), .table_dest_o(tdest), .table_wr_o(twr), .table_data_high_o(thigh),
      .alu_result_o(ares), .status_o(st), .alu_dest_o(adest), .alu_wr_o(awr)
   );
   flow_decoder_model i_flow_decoder_model
   (
      .clock_i(clock_i), .rst_b_i(rst_b_i), .next_i(next_c), .go_i(go), .busy_o(busy),
      .ready_i(ready), .instr_valid_i(ivalid), .cmd_o(cmd)
   );
   // clock of 10 ns
   always #5 clock_i = ~clock_i;
   // ==================================================
   // tasks
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("wrong value at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic conclude;
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic pm_put(input logic [10:0] a, input logic [14:0] d);
      @(posedge clock_i);
      pm_wr <= '{1'b1, a, d};
      @(posedge clock_i);
      pm_wr.en <= 1'b0;
   endtask
   // returns 1 ns after the edge that takes the command
   task automatic issue(input flow_pkg::flow_op_t op, input flow_pkg::alu_op_t aop,
                        input logic [10:0] t, input logic [7:0] a, input logic [7:0] b);
      @(posedge clock_i);
      next_c <= '{1'b1, op, aop, t, a, a, b, 8'h40};
      go <= 1'b1;
      @(posedge clock_i);
      go <= 1'b0;
      #1;
      n = 0;
      while (busy && n < 40)
      begin
         @(posedge clock_i);
         #1;
         n++;
      end
      if (busy)
         n_mismatch++;
   endtask
   task automatic step;
      @(posedge clock_i);
      #1;
   endtask
   // ==================================================
   // watchdog, far beyond the hundred or so cycles the tests take
   initial
   begin
      repeat (5000) @(posedge clock_i);
      n_mismatch++;
      conclude();
   end
   // ==================================================
   // main sequence
   initial
   begin
      repeat (12) @(posedge clock_i);
      rst_b_i <= 1'b1;
      #1;
      chk(pc, 16'h0000);
      chk(full, 16'h0000);
      pm_put(11'h05a, 15'h2eed);
      pm_put(11'h234, 15'h5abc);
      pm_put(11'h734, 15'h1234);
      epc = 11'h000;
      // ordinary alu cases
      foreach (rows[i])
      begin
         issue(flow_pkg::OP_ALU, rows[i].op, 11'h000, rows[i].a, rows[i].b);
         epc = epc + 11'h001;
         chk(awr, 16'h0001);
         chk(ares, rows[i].res);
         chk(adest, 16'h0040);
         chk(st.z, rows[i].res == 8'h00);
         if (rows[i].op inside {flow_pkg::ALU_ADD, flow_pkg::ALU_SUB})
            chk(st.c, rows[i].c);
         chk(pc, epc);
      end
      // low byte write jumps in page and leaves one dummy cycle
      issue(flow_pkg::OP_LOW_WR, flow_pkg::ALU_PASS, 11'h000, 8'h5a, 8'h00);
      chk(pc, {epc[10:8], 8'h5a});
      chk(pc_low_byte, 16'h005a);
      chk(ivalid, 16'h0000);
      step();
      chk(ivalid, 16'h0001);
      chk(instr, 16'h2eed);
      // table reads with interrupts held off throughout
      @(posedge clock_i);
      tp_low <= 8'h34;
      tp_high <= 3'h2;
      issue(flow_pkg::OP_TBL_STD, flow_pkg::ALU_PASS, 11'h000, 8'h00, 8'h00);
      chk(twr, 16'h0000);
      chk(ready, 16'h0000);
      step();
      chk(twr, 16'h0001);
      chk(tlow, 16'h00bc);
      chk(thigh, 16'h005a);
      chk(tdest, 16'h0040);
      issue(flow_pkg::OP_TBL_LAST, flow_pkg::ALU_PASS, 11'h000, 8'h00, 8'h00);
      step();
      step();
      chk(tlow, 16'h0034);
      chk(thigh, 16'h0012);
      // a taken skip drops the next word, a jump comes back
      issue(flow_pkg::OP_ALU, flow_pkg::ALU_SKIP_Z, 11'h000, 8'h00, 8'h00);
      chk(pc, 16'h005e);
      chk(ivalid, 16'h0000);
      issue(flow_pkg::OP_JMP, flow_pkg::ALU_PASS, 11'h05c, 8'h00, 8'h00);
      chk(pc, 16'h005c);
      epc = 11'h05c;
      // fill the stack, hold an interrupt off, then overflow it
      for (int k = 1; k <= 5; k++)
      begin
         if (k == 5)
         begin
            chk(full, 16'h0001);
            @(posedge clock_i);
            irq_pending <= 1'b1;
            repeat (6)
            begin
               step();
               chk(ack, 16'h0000);
            end
         end
         ret[k - 1] = epc + 11'h001;
         epc = 11'(k) << 8;
         issue(flow_pkg::OP_CALL, flow_pkg::ALU_PASS, epc, 8'h00, 8'h00);
      end
      step();
      chk(pc, 16'h0500);
      chk(full, 16'h0001);
      issue(flow_pkg::OP_SUB_RETURN, flow_pkg::ALU_PASS, 11'h000, 8'h00, 8'h00);
      step();
      chk(pc, ret[4]);
      n = 0;
      while (ack !== 1'b1 && n < 8)
      begin
         step();
         n++;
      end
      chk(ack, 16'h0001);
      @(posedge clock_i);
      irq_pending <= 1'b0;
      #1;
      chk(pc, VEC);
      // pops come back newest first; the first call's entry was dropped
      for (int i = 0; i < 4; i++)
      begin
         issue(i == 0 ? flow_pkg::OP_INT_RETURN : flow_pkg::OP_SUB_RETURN, flow_pkg::ALU_PASS,
               11'h000, 8'h00, 8'h00);
         step();
         chk(pc, ret[4 - i]);
      end
      chk(thigh, 16'h0012);
      // a freeze holds the pc and refuses commands
      @(posedge clock_i);
      en <= 1'b0;
      repeat (2) step();
      chk(ready, 16'h0000);
      chk(pc, ret[1]);
      @(posedge clock_i);
      en <= 1'b1;
      conclude();
   end
endmodule // tb_program_flow_stack_table_read
